// ===== design/lcdscd_pkg.sv
// Package: register map, field positions and reset values of the panel driver
package lcdscd_pkg;
  // Register byte offsets on the AXI4-Lite port
  localparam logic [11:0] TimingCfgOff = 12'h000;
  localparam logic [11:0] SupplyCtlOff = 12'h004;
  localparam logic [11:0] SegDisOff0 = 12'h008;
  localparam logic [11:0] SegDisOff1 = 12'h00c;
  localparam logic [11:0] SegDisOff2 = 12'h010;
  localparam logic [11:0] PortDirOff0 = 12'h014;
  localparam logic [11:0] PortDirOff1 = 12'h018;
  localparam logic [11:0] PortDirOff2 = 12'h01c;
  localparam logic [11:0] PortDirOff3 = 12'h020;
  localparam logic [11:0] StatusOff = 12'h024;
  // Display memory window, one word per byte of panel memory
  localparam logic [11:0] DispMemOff = 12'h840;
  localparam int DispMemBytes = 36;
  localparam int NumSeg = 36;
  localparam int NumCom = 8;
  localparam int MaxPixels = 256;
  // Timing configuration fields
  localparam int DutyLsb = 0;
  localparam int BiasBit = 3;
  localparam int DivLsb = 5;
  localparam int SrcBit = 7;
  // Supply control fields
  localparam int MultBit = 0;
  localparam int Level3Bit = 1;
  localparam int EnableBit = 3;
  // Reset values
  localparam logic [7:0] TimingCfgRst = 8'h00;
  localparam logic [7:0] SupplyCtlRst = 8'h00;
  localparam logic [7:0] SegDisRst0 = 8'hff;
  localparam logic [7:0] SegDisRst1 = 8'hff;
  localparam logic [7:0] SegDisRst2 = 8'h0f;
  localparam logic [7:0] PortDirRst = 8'h00;
  // Count source prescales (clock cycles per source tick)
  localparam logic [7:0] SrcFastDiv = 8'h01;
  localparam logic [7:0] SrcSlowDiv = 8'h10;
  // Divider ratios selected by the two ratio bits
  localparam logic [9:0] DivRatio0 = 10'h001;
  localparam logic [9:0] DivRatio1 = 10'h002;
  localparam logic [9:0] DivRatio2 = 10'h004;
  localparam logic [9:0] DivRatio3 = 10'h008;
  // Drive levels on each line
  localparam logic [1:0] LevelGnd = 2'h0;
  localparam logic [1:0] LevelOne = 2'h1;
  localparam logic [1:0] LevelTwo = 2'h2;
  localparam logic [1:0] LevelThree = 2'h3;
  // Bus responses
  localparam logic [1:0] RespOkay = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;
endpackage

// ===== design/lcdscd_divider.sv
// Divider: one-cycle tick every ratio step pulses while run is set
`timescale 1ns/10ps
module lcdscd_divider
  import lcdscd_pkg::*;
#(
  parameter int Width = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic step,
  input wire logic [Width-1:0] ratio,
  // Result
  output logic tick
);
  logic [Width-1:0] count_q;
  wire logic last = (count_q >= ratio - Width'(1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= run && step && last;
      if (!run)
        count_q <= '0;
      else if (step)
        count_q <= last ? '0 : count_q + Width'(1);
    end
  end
endmodule

// ===== design/lcdscd_top.sv
// Top: segment/common panel driver with AXI4-Lite register port
// How it works
// - Enable bit set: scanner reads memory and drives the panel alone.
// - Thirty-six segment outputs and eight common outputs at most.
// - Up to 256 pixels, only with eight-common duty.
// - Duty field 000,001,010,011,111 selects commons 0, 0-1, 0-2, 0-3, 0-7.
// - Scanned commons depend only on the duty setting.
// - While enabled, unused commons carry the unselected waveform.
// - After reset every common drives the supply level.
// - After reset shared pins are inputs, showing the pulled-up level.
// - Display memory is 36 bytes 0x840-0x8cf, one byte per segment.
// - A one bit lights the segment at that segment and common crossing.
// - Drive clock is the count source divided by the divider ratio.
// - Frame rate is drive clock divided by duty: one scan per frame.
// - Timing config: duty 2:0, bias 3, divider 6:5, source 7.
// - One bias bit picks the scheme; third bias drives all four levels on each line, half bias three.
`timescale 1ns/10ps
module lcdscd_top
  import lcdscd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Panel lines, levels as 2-bit codes
  output logic [2*NumCom-1:0] commonLines,
  output logic [2*NumSeg-1:0] segmentLines,
  output logic [NumSeg-1:0] segmentDriveEn,
  output logic multiplierOn,
  output logic level3Connect
);
  typedef enum logic [1:0] {BusIdle, BusResp} lcdscd_bus_type;

  logic [7:0] timingCfg_q;
  logic [7:0] supplyCtl_q;
  logic [7:0] segDis_q [3];
  logic [7:0] portDir_q [4];
  logic [7:0] dispMem_q [DispMemBytes];
  logic [2:0] comIdx_q;
  logic phase_q;
  logic frameDone_q;
  lcdscd_bus_type wrState_q;
  lcdscd_bus_type rdState_q;
  logic [11:0] awaddr_q;
  logic awHeld_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wHeld_q;

  // Field decode
  wire logic [2:0] dutySel = timingCfg_q[DutyLsb+:3];
  wire logic biasThird = timingCfg_q[BiasBit];
  wire logic [1:0] divSel = timingCfg_q[DivLsb+:2];
  wire logic srcSlow = timingCfg_q[SrcBit];
  wire logic enable = supplyCtl_q[EnableBit];

  // Last active common for each duty code
  wire logic [2:0] lastCom = (dutySel == 3'h7) ? 3'h7 :
    (dutySel > 3'h3) ? 3'h3 : dutySel;

  // Count source and drive-clock divider
  wire logic [7:0] srcRatio = srcSlow ? SrcSlowDiv : SrcFastDiv;
  wire logic [9:0] divRatio = (divSel == 2'h0) ? DivRatio0 :
    (divSel == 2'h1) ? DivRatio1 :
    (divSel == 2'h2) ? DivRatio2 : DivRatio3;
  logic srcTick;
  logic driveTick;

  lcdscd_divider #(.Width(8)) srcDiv (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(enable),
    .step(1'b1),
    .ratio(srcRatio),
    .tick(srcTick)
  );

  lcdscd_divider #(.Width(10)) drvDiv (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(enable),
    .step(srcTick),
    .ratio(divRatio),
    .tick(driveTick)
  );

  // Scan position: each completed frame inverts polarity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comIdx_q <= 3'h0;
      phase_q <= 1'b0;
      frameDone_q <= 1'b0;
    end else if (ce) begin
      frameDone_q <= 1'b0;
      if (!enable) begin
        comIdx_q <= 3'h0;
        phase_q <= 1'b0;
      end else if (driveTick) begin
        if (comIdx_q >= lastCom) begin
          comIdx_q <= 3'h0;
          phase_q <= ~phase_q;
          frameDone_q <= 1'b1;
        end else begin
          comIdx_q <= comIdx_q + 3'h1;
        end
      end
    end
  end

  // Level codes for the bias scheme
  wire logic [1:0] selHi = phase_q ? LevelGnd : LevelThree;
  wire logic [1:0] selLo = phase_q ? LevelThree : LevelGnd;
  wire logic [1:0] unselCom = biasThird ?
    (phase_q ? LevelTwo : LevelOne) : LevelOne;
  wire logic [1:0] unselSeg = biasThird ?
    (phase_q ? LevelOne : LevelTwo) : LevelTwo;

  logic [2*NumCom-1:0] comNext;
  logic [2*NumSeg-1:0] segNext;
  logic [NumSeg-1:0] segEnNext;

  always_comb begin
    for (int c = 0; c < NumCom; c++) begin
      if (!enable)
        comNext[2*c+:2] = LevelThree;
      else if (c == int'(comIdx_q))
        comNext[2*c+:2] = selHi;
      else
        comNext[2*c+:2] = unselCom;
    end
  end

  // Segment drive: pixel at current common, shared pins per direction
  always_comb begin
    for (int s = 0; s < NumSeg; s++) begin
      segNext[2*s+:2] = dispMem_q[s][comIdx_q] ? selLo : unselSeg;
      if (s < 8 || s >= 32)
        segEnNext[s] = enable;
      else if (s < 28)
        segEnNext[s] = enable && portDir_q[s/8-1][s%8] &&
          !segDis_q[(s-8)/8][(s-8)%8];
      else
        segEnNext[s] = enable && portDir_q[3][s%8] &&
          !segDis_q[2][s-28];
      // Commons 4-7 double as segments 35..32 below eight-common duty
      if (s >= 32 && dutySel == 3'h7)
        segEnNext[s] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      commonLines <= {NumCom{LevelThree}};
      segmentLines <= '0;
      segmentDriveEn <= '0;
      multiplierOn <= 1'b0;
      level3Connect <= 1'b0;
    end else if (ce) begin
      commonLines <= comNext;
      segmentLines <= segNext;
      segmentDriveEn <= segEnNext;
      multiplierOn <= supplyCtl_q[MultBit];
      level3Connect <= supplyCtl_q[Level3Bit];
    end
  end

  // Write channel: address and data taken in either order
  wire logic awTake = awvalid && awready;
  wire logic wTake = wvalid && wready;
  wire logic [11:0] wAddr = awHeld_q ? awaddr_q : awaddr;
  wire logic [31:0] wData = wHeld_q ? wdata_q : wdata;
  wire logic [3:0] wStrb = wHeld_q ? wstrb_q : wstrb;
  wire logic haveAw = awHeld_q || awTake;
  wire logic haveW = wHeld_q || wTake;
  wire logic doWrite = (wrState_q == BusIdle) && haveAw && haveW;
  wire logic wrMem = (wAddr >= DispMemOff) &&
    (wAddr < DispMemOff + 12'(4*DispMemBytes));
  wire logic [5:0] wMemIdx = 6'((wAddr - DispMemOff) >> 2);
  wire logic wrHit = wrMem || (wAddr <= StatusOff);
  wire logic wrByte = doWrite && wStrb[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timingCfg_q <= TimingCfgRst;
      supplyCtl_q <= SupplyCtlRst;
      segDis_q[0] <= SegDisRst0;
      segDis_q[1] <= SegDisRst1;
      segDis_q[2] <= SegDisRst2;
      for (int i = 0; i < 4; i++)
        portDir_q[i] <= PortDirRst;
      for (int i = 0; i < DispMemBytes; i++)
        dispMem_q[i] <= 8'h00;
    end else if (ce && wrByte) begin
      case (wAddr)
        TimingCfgOff: timingCfg_q <= wData[7:0];
        SupplyCtlOff: supplyCtl_q <= wData[7:0];
        SegDisOff0: segDis_q[0] <= wData[7:0];
        SegDisOff1: segDis_q[1] <= wData[7:0];
        SegDisOff2: segDis_q[2] <= {4'h0, wData[3:0]};
        PortDirOff0: portDir_q[0] <= wData[7:0];
        PortDirOff1: portDir_q[1] <= wData[7:0];
        PortDirOff2: portDir_q[2] <= wData[7:0];
        PortDirOff3: portDir_q[3] <= wData[7:0];
        default: begin
          if (wrMem)
            dispMem_q[wMemIdx] <= wData[7:0];
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RespOkay;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      wrState_q <= BusIdle;
    end else if (ce) begin
      case (wrState_q)
        BusIdle: begin
          if (awTake) begin
            awaddr_q <= awaddr;
            awHeld_q <= 1'b1;
          end
          if (wTake) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
            wHeld_q <= 1'b1;
          end
          awready <= !haveAw;
          wready <= !haveW;
          if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? RespOkay : RespSlvErr;
            awready <= 1'b0;
            wready <= 1'b0;
            wrState_q <= BusResp;
          end
        end
        BusResp: begin
          if (bready) begin
            bvalid <= 1'b0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            wrState_q <= BusIdle;
          end
        end
        default: wrState_q <= BusIdle;
      endcase
    end
  end

  // Read decode
  wire logic rdMem = (araddr >= DispMemOff) &&
    (araddr < DispMemOff + 12'(4*DispMemBytes));
  wire logic [5:0] rMemIdx = 6'((araddr - DispMemOff) >> 2);
  logic [7:0] rByte;
  logic rHit;

  always_comb begin
    rHit = 1'b1;
    case (araddr)
      TimingCfgOff: rByte = timingCfg_q;
      SupplyCtlOff: rByte = supplyCtl_q;
      SegDisOff0: rByte = segDis_q[0];
      SegDisOff1: rByte = segDis_q[1];
      SegDisOff2: rByte = segDis_q[2];
      PortDirOff0: rByte = portDir_q[0];
      PortDirOff1: rByte = portDir_q[1];
      PortDirOff2: rByte = portDir_q[2];
      PortDirOff3: rByte = portDir_q[3];
      StatusOff: rByte = {3'h0, frameDone_q, phase_q, comIdx_q};
      default: begin
        rHit = rdMem;
        rByte = rdMem ? dispMem_q[rMemIdx] : 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RespOkay;
      rdState_q <= BusIdle;
    end else if (ce) begin
      case (rdState_q)
        BusIdle: begin
          arready <= 1'b1;
          if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rByte};
            rresp <= rHit ? RespOkay : RespSlvErr;
            rdState_q <= BusResp;
          end
        end
        BusResp: begin
          if (rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
            rdState_q <= BusIdle;
          end
        end
        default: rdState_q <= BusIdle;
      endcase
    end
  end
endmodule

// ===== dv/lcdscd_panel.sv
// Passive panel model: records scanned commons and lit cells of segment 0
`timescale 1ns/10ps
module lcdscd_panel
  import lcdscd_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic clr,
  // Panel electrodes
  input wire logic [2*NumCom-1:0] commonLines,
  input wire logic [2*NumSeg-1:0] segmentLines,
  // Observations
  output logic [NumCom-1:0] sawCom,
  output logic [NumCom-1:0] litSeg0
);
  logic [NumCom-1:0] selNow;
  logic [NumCom-1:0] litNow;
  for (genvar c = 0; c < NumCom; c++) begin : g_com
    // Full swing marks the scanned common
    assign selNow[c] = commonLines[2*c+1] == commonLines[2*c];
    // Opposite full swing across the cell lights it
    assign litNow[c] = selNow[c] &&
      segmentLines[1:0] == ~commonLines[2*c+:2];
  end
  always_ff @(posedge clk) begin
    if (clr) begin
      sawCom <= '0;
      litSeg0 <= '0;
    end else begin
      sawCom <= sawCom | selNow;
      litSeg0 <= litSeg0 | litNow;
    end
  end
endmodule

// ===== dv/lcdscd_asserts.sv
// Checker for the panel driver ports
`timescale 1ns/10ps
module lcdscd_asserts
  import lcdscd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Panel
  input wire logic [2*NumCom-1:0] commonLines,
  input wire logic [NumSeg-1:0] segmentDriveEn,
  input wire logic multiplierOn,
  input wire logic level3Connect
);
  logic [7:0] cfg_q;
  logic [7:0] quiet_q;
  logic [7:0] usedMask;
  logic [7:0] midLvl;
  logic [7:0] twoLvl;
  logic en_q;
  wire wrTaken = awvalid && awready && wvalid && wready;
  // Either bias: checks run while enabled once no write has been taken for 255 cycles
  wire settled = en_q && quiet_q == 8'hff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the written configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= 8'h00;
      en_q <= 1'b0;
      quiet_q <= 8'h00;
    end else if (wrTaken) begin
      cfg_q <= (awaddr == TimingCfgOff) ? wdata[7:0] : cfg_q;
      en_q <= (awaddr == SupplyCtlOff) ? wdata[EnableBit] : en_q;
      quiet_q <= 8'h00;
    end else if (quiet_q != 8'hff) begin
      quiet_q <= quiet_q + 8'h01;
    end
  end
  assign usedMask = (cfg_q[2:0] == 3'h7) ? 8'hff :
    (cfg_q[2:0] == 3'h0) ? 8'h01 : (cfg_q[2:0] == 3'h1) ? 8'h03 :
    (cfg_q[2:0] == 3'h2) ? 8'h07 : 8'h0f;
  for (genvar c = 0; c < 8; c++) begin : g_mid
    assign midLvl[c] = commonLines[2*c+1] ^ commonLines[2*c];
    assign twoLvl[c] = commonLines[2*c+1] && !commonLines[2*c];
  end
  AST_RST_LEVELS: assert property (
    $fell(rst) |-> commonLines == 16'hffff && segmentDriveEn == '0)
    else $error("levels wrong after reset");
  AST_UNUSED_COM: assert property (
    settled |-> (midLvl | usedMask) == 8'hff)
    else $error("unused common selected");
  AST_ONE_SCANNED: assert property (
    settled |-> $onehot(~midLvl))
    else $error("not exactly one common scanned");
  AST_HALF_BIAS: assert property (
    settled && !cfg_q[BiasBit] |-> twoLvl == 8'h00)
    else $error("level two used at half bias");
  AST_HIGH_SEG_OFF: assert property (
    en_q && cfg_q[2:0] == 3'h7 && quiet_q > 8'h03 |->
    segmentDriveEn[35:32] == 4'h0)
    else $error("segments 32 to 35 driven at eight commons");
  AST_READ_LAT: assert property (
    arvalid && arready |=> rvalid ##0 !arready)
    else $error("read answer late");
  AST_READ_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  AST_WRITE_RESP: assert property (
    wrTaken |=> bvalid && !awready && !wready)
    else $error("write answer wrong");
  AST_UNMAPPED: assert property (
    arvalid && arready && araddr == 12'h8d0 |=>
    rresp == RespSlvErr && rdata == '0)
    else $error("unmapped read not refused");
  AST_SUPPLY_COPY: assert property (
    $changed({multiplierOn, level3Connect}) |-> bvalid || $past(bvalid))
    else $error("supply bits moved without a write");
  cover property (wrTaken ##1 bvalid);
  cover property (rvalid && rready);
  cover property (settled && !midLvl[1]);
endmodule
bind lcdscd_top lcdscd_asserts u_lcdscd_asserts (.clk(clk), .rst(rst),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .commonLines(commonLines),
  .segmentDriveEn(segmentDriveEn), .multiplierOn(multiplierOn),
  .level3Connect(level3Connect));

// ===== dv/tb.sv
// Testbench for the panel driver
`timescale 1ns/10ps
module tb
  import lcdscd_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, clr = 1'b0, ce = 1'b1, com0_q = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, multiplierOn, level3Connect;
  logic [1:0] bresp, rresp;
  logic [15:0] commonLines;
  logic [71:0] segmentLines;
  logic [35:0] segmentDriveEn;
  logic [7:0] sawCom, litSeg0;
  int failures = 0, compares = 0, cycles = 0;
  wire com0Sel = commonLines[1] == commonLines[0];

  lcdscd_top u_lcdscd_top (.clk(clk), .rst(rst), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .commonLines(commonLines), .segmentLines(segmentLines),
    .segmentDriveEn(segmentDriveEn), .multiplierOn(multiplierOn),
    .level3Connect(level3Connect));
  lcdscd_panel u_lcdscd_panel (.clk(clk), .clr(clr),
    .commonLines(commonLines), .segmentLines(segmentLines),
    .sawCom(sawCom), .litSeg0(litSeg0));

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    com0_q <= com0Sel;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      close_out();
    end
  end

  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, er);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    // Late ready: the slave must hold its answer for a cycle
    rready <= 1'b1;
    @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    logic [11:0] adr [6] = '{TimingCfgOff, SupplyCtlOff, SegDisOff0,
                             SegDisOff1, SegDisOff2, PortDirOff0};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h0f, 8'h00};
    chk(commonLines, 16'hffff);
    chk(segmentDriveEn, 36'h0);
    foreach (adr[i]) begin
      rd(adr[i], d, r);
      chk(d, {24'h0, rv[i]});
    end
    wr(TimingCfgOff, 8'heb, RespOkay);
    rd(TimingCfgOff, d, r);
    chk(d, 32'heb);
    wr(12'h8cc, 8'ha5, RespOkay);
    rd(12'h8cc, d, r);
    chk(d, 32'ha5);
    wr(12'h8d0, 8'h11, RespSlvErr);
    rd(12'h8d0, d, r);
    chk({r, d}, {RespSlvErr, 32'h0});
  endtask

  // Fastest tick, third bias, one duty code
  task automatic t_scan(input logic [2:0] code, input logic [7:0] used);
    wr(SupplyCtlOff, 8'h00, RespOkay);
    wr(DispMemOff, 8'h5a, RespOkay);
    wr(TimingCfgOff, {5'h01, code}, RespOkay);
    wr(SupplyCtlOff, 8'h08, RespOkay);
    repeat (20) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (40) @(posedge clk);
    chk(sawCom, used);
    chk(litSeg0, 8'h5a & used);
    chk(segmentDriveEn, {{4{code != 3'h7}}, 24'h0, 8'hff});
  endtask

  // Common 0 recurs once per frame
  task automatic t_rate(input logic [7:0] cfg, input int period);
    int n;
    n = 0;
    wr(SupplyCtlOff, 8'h00, RespOkay);
    wr(TimingCfgOff, cfg, RespOkay);
    wr(SupplyCtlOff, 8'h08, RespOkay);
    repeat (300) @(posedge clk);
    do @(posedge clk); while (!(com0Sel && !com0_q));
    do begin
      @(posedge clk);
      n = n + 1;
    end while (!(com0Sel && !com0_q));
    chk(n, period);
  endtask

  task automatic t_pin(input logic [11:0] a, input logic [7:0] d,
                       input logic e);
    wr(a, d, RespOkay);
    repeat (4) @(posedge clk);
    chk(segmentDriveEn[8], e);
  endtask

  task automatic t_supply();
    logic [31:0] d;
    logic [1:0] r;
    wr(SegDisOff2, 8'h0f, RespOkay);
    wr(TimingCfgOff, 8'h0f, RespOkay);
    wr(SupplyCtlOff, 8'h0a, RespOkay);
    chk({multiplierOn, level3Connect}, 2'b01);
    wr(SupplyCtlOff, 8'h0b, RespOkay);
    chk({multiplierOn, level3Connect}, 2'b11);
    rd(SupplyCtlOff, d, r);
    chk(d, 32'h0b);
    wr(SupplyCtlOff, 8'h08, RespOkay);
    chk({multiplierOn, level3Connect}, 2'b00);
  endtask

  initial begin
    logic [2:0] codes [6];
    logic [7:0] used [6];
    logic [15:0] frozen;
    codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    used = '{8'h01, 8'h03, 8'h07, 8'h0f, 8'h0f, 8'hff};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    foreach (codes[i]) t_scan(codes[i], used[i]);
    t_rate(8'hca, 192);
    // Half bias, two commons, divide by eight
    t_rate(8'h61, 16);
    t_pin(PortDirOff0, 8'h01, 1'b0);
    t_pin(SegDisOff0, 8'hfe, 1'b1);
    t_pin(PortDirOff0, 8'h00, 1'b0);
    t_supply();
    // Scan runs every cycle here, so holding ce low must freeze it
    ce <= 1'b0;
    @(posedge clk);
    frozen = commonLines;
    repeat (5) @(posedge clk);
    chk(commonLines, frozen);
    ce <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(commonLines, 16'hffff);
    chk(segmentDriveEn, 36'h0);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule
